// file: logic/sac_guard.sv
// Register access guard and CPU privilege mode control.
`timescale 1ns/100ps
`include "sac_defs.svh"
// What this block does
// [R1] Each register access is allowed by register function and current CPU mode.
// [R2] Key register is write-only; every read is refused.
// [R3] Key writes are allowed only in modes the policy permits.
// [R4] Random output is read-only; reads allowed only in permitted modes.
// [R5] Forbidden or unimplemented register access raises an exception.
// [R6] A banked register has one copy for application mode, one for supervisor.
// [R7] Firmware mode reaches each of 14 groups only after application grants it.
// [R8] Rights of non-group registers are fixed in hardware.
// [R9] A firmware vector call switches to firmware mode.
// [R10] An exception sets the in-exception flag.
// [R11] A further exception while in-exception forces a reset.
// [R12] Interrupts run in application or firmware mode by a run-time option.
// [R13] Only application mode may change the interrupt mode option.
// [R14] The return instruction restores the mode active before the event.
// [R15] Application mode reaches all group and system management registers.
// [R16] Grants are 14 individual bits held for the access checker.
// [R17] Supervisor means boot, test or firmware mode.
// [R18] An exception is non-maskable and enters application mode.
// [R19] A refused access changes nothing and reads back zero.
// [R20] The return instruction clears the in-exception flag.
module sac_guard (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB register access from the CPU
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU control-flow events, one-cycle pulses, and the test_en strap level
   input wire logic boot_done,
   input wire logic test_en,
   input wire logic firmware_entry_vector,
   input wire logic exc_event,
   input wire logic irq_event,
   input wire logic return_from_handler_instr,
   // Mode and status
   output sac_pkg::sac_mode_type cpu_mode,
   output logic in_exc,
   output logic sfr_exc,
   output logic reset_req,
   // Configuration to the rest of the chip
   output logic [31:0] key_word,
   output logic [31:0] mmu_cfg,
   output logic [31:0] clk_cfg,
   output logic [31:0] tamper_cfg
);

   sac_pkg::sac_mode_type mode_q;
   sac_pkg::sac_mode_type prev_q;
   sac_pkg::sac_grant_type grant_q;
   logic irq_fw_q;
   logic in_exc_q;
   logic reset_req_q;
   logic sfr_exc_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] bank_app_q;
   logic [31:0] bank_sup_q;
   logic [31:0] key_q;
   logic [31:0] mmu_q;
   logic [31:0] clk_q;
   logic [31:0] tamp_q;
   logic [31:0] lfsr_q;
   logic [31:0] peri_q [`SAC_NGRP];
   logic acc;
   logic hit;
   logic ok;
   logic wen;
   logic is_app;
   logic [3:0] gidx;
   logic [31:0] rdat;

   // Firmware mode needs the group grant; every other mode passes.
   function automatic logic grp_ok(input sac_pkg::sac_mode_type m,
                                   input sac_pkg::sac_grant_type g,
                                   input logic [3:0] i);
      grp_ok = (m != sac_pkg::SAC_FW) || g[i];
   endfunction

   assign acc = psel && penable && !pready_q;
   assign is_app = (mode_q == sac_pkg::SAC_APP);
   assign gidx = 4'((paddr - `SAC_OFS_PERI) >> 2);
   assign wen = acc && pwrite && hit && ok;

   // Access decision per register function and mode.
   always_comb begin
      hit = 1'b1;
      ok = 1'b0;
      rdat = `SAC_RST_WORD;
      if (paddr[1:0] != 2'h0) begin
         hit = 1'b0;
      end else begin
         case (paddr)
            `SAC_OFS_GRANT: begin
               ok = !pwrite || is_app; // R13 R16 R8
               rdat = {18'h00000, grant_q};
            end
            `SAC_OFS_IRQCFG: begin
               ok = !pwrite || is_app; // R13
               rdat = {31'h00000000, irq_fw_q};
            end
            `SAC_OFS_STAT: begin
               ok = !pwrite; // R8
               rdat = {26'h0000000, prev_q, in_exc_q, 1'b0, mode_q};
            end
            `SAC_OFS_BANK: begin
               ok = 1'b1;
               rdat = is_app ? bank_app_q : bank_sup_q; // R6
            end
            `SAC_OFS_KEY: begin
               ok = pwrite && grp_ok(mode_q, grant_q, `SAC_GRP_KEY); // R2 R3
            end
            `SAC_OFS_RNG: begin
               ok = !pwrite && grp_ok(mode_q, grant_q, `SAC_GRP_RNG); // R4
               rdat = lfsr_q;
            end
            `SAC_OFS_MMU, `SAC_OFS_CLK, `SAC_OFS_TAMP: begin
               // Fixed right: system management is closed to firmware mode.
               ok = (mode_q != sac_pkg::SAC_FW); // R15 R8 R17
               rdat = (paddr == `SAC_OFS_MMU) ? mmu_q :
                      (paddr == `SAC_OFS_CLK) ? clk_q : tamp_q;
            end
            default: begin
               if (paddr >= `SAC_OFS_PERI && paddr <= `SAC_OFS_PERI_END) begin
                  ok = grp_ok(mode_q, grant_q, gidx); // R7 R15
                  rdat = peri_q[gidx];
               end else begin
                  hit = 1'b0; // R5
               end
            end
         endcase
      end
   end

   // APB answer: one wait state, pready high for exactly one cycle.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `SAC_RST_WORD;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !(hit && ok); // R1 R5
         // A refused read never puts register contents on the bus.
         prdata_q <= (acc && !pwrite && hit && ok) ? rdat : `SAC_RST_WORD; // R19 R2
      end
   end

   // Exception request toward the CPU for a refused access.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sfr_exc_q <= 1'b0;
      end else begin
         sfr_exc_q <= acc && !(hit && ok); // R5
      end
   end

   // Grant and interrupt option, application mode only.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         grant_q <= `SAC_RST_GRANT;
         irq_fw_q <= 1'b0;
      end else begin
         if (wen && paddr == `SAC_OFS_GRANT) begin
            grant_q <= pwdata[13:0]; // R16 R7
         end
         if (wen && paddr == `SAC_OFS_IRQCFG) begin
            irq_fw_q <= pwdata[0]; // R12 R13
         end
      end
   end

   // Data registers; refused writes never reach them.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         bank_app_q <= `SAC_RST_WORD;
         bank_sup_q <= `SAC_RST_WORD;
         key_q <= `SAC_RST_WORD;
         mmu_q <= `SAC_RST_WORD;
         clk_q <= `SAC_RST_WORD;
         tamp_q <= `SAC_RST_WORD;
         for (int i = 0; i < `SAC_NGRP; i++) begin
            peri_q[i] <= `SAC_RST_WORD;
         end
      end else if (wen) begin // R19
         case (paddr)
            `SAC_OFS_BANK: begin
               if (is_app) begin
                  bank_app_q <= pwdata; // R6
               end else begin
                  bank_sup_q <= pwdata; // R6
               end
            end
            `SAC_OFS_KEY: key_q <= pwdata; // R3
            `SAC_OFS_MMU: mmu_q <= pwdata; // R15
            `SAC_OFS_CLK: clk_q <= pwdata; // R15
            `SAC_OFS_TAMP: tamp_q <= pwdata; // R15
            default: begin
               if (paddr >= `SAC_OFS_PERI && paddr <= `SAC_OFS_PERI_END) begin
                  peri_q[gidx] <= pwdata; // R7
               end
            end
         endcase
      end
   end

   // Free-running random source; a plain LFSR stands in for the entropy core.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         lfsr_q <= `SAC_RST_SEED;
      end else begin
         lfsr_q <= {lfsr_q[30:0], ^(lfsr_q & `SAC_LFSR_TAPS)};
      end
   end

   // Mode control. Priority: exception, interrupt, vector call, return.
   // Only one level is saved: a nested exception resets the chip anyway.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         mode_q <= sac_pkg::SAC_BOOT;
         prev_q <= sac_pkg::SAC_BOOT;
         in_exc_q <= 1'b0;
         reset_req_q <= 1'b0;
      end else if (!reset_req_q) begin
         if (exc_event) begin
            if (in_exc_q) begin
               reset_req_q <= 1'b1; // R11
            end else begin
               prev_q <= mode_q;
               mode_q <= sac_pkg::SAC_APP; // R18
               in_exc_q <= 1'b1; // R10
            end
         end else if (irq_event) begin
            prev_q <= mode_q;
            mode_q <= irq_fw_q ? sac_pkg::SAC_FW : sac_pkg::SAC_APP; // R12
         end else if (firmware_entry_vector) begin
            prev_q <= mode_q;
            mode_q <= sac_pkg::SAC_FW; // R9
         end else if (return_from_handler_instr) begin
            mode_q <= prev_q; // R14
            in_exc_q <= 1'b0; // R20
         end else if (boot_done && mode_q == sac_pkg::SAC_BOOT) begin
            // Boot mode is left here; a later return restores it while prev_q still holds SAC_BOOT.
            mode_q <= test_en ? sac_pkg::SAC_TEST : sac_pkg::SAC_FW; // R17
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cpu_mode = mode_q;
   assign in_exc = in_exc_q;
   assign sfr_exc = sfr_exc_q;
   assign reset_req = reset_req_q;
   assign key_word = key_q;
   assign mmu_cfg = mmu_q;
   assign clk_cfg = clk_q;
   assign tamper_cfg = tamp_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_key_read_zero: assert property ( // R2
      acc && !pwrite && paddr == `SAC_OFS_KEY |=> pslverr_q && prdata_q == 32'h00000000)
      else $error("key read not refused");
   a_key_write_gate: assert property ( // R3
      acc && pwrite && paddr == `SAC_OFS_KEY && mode_q == sac_pkg::SAC_FW && !grant_q[`SAC_GRP_KEY]
      |=> key_q == $past(key_q) && pslverr_q)
      else $error("ungranted key write taken");
   a_rng_fw_gate: assert property ( // R4
      acc && !pwrite && paddr == `SAC_OFS_RNG && mode_q == sac_pkg::SAC_FW && !grant_q[`SAC_GRP_RNG]
      |=> pslverr_q ##0 prdata_q == 32'h00000000)
      else $error("ungranted random read answered");
   a_err_raises_exc: assert property ( // R5
      pready_q && pslverr_q |-> sfr_exc_q)
      else $error("refused access without exception");
   a_grant_app_only: assert property ( // R13
      acc && pwrite && paddr == `SAC_OFS_GRANT && !is_app |=> $stable(grant_q))
      else $error("grant changed outside application mode");
   a_ready_one_cycle: assert property (
      acc |=> pready_q ##1 !pready_q)
      else $error("ready not a single cycle");
   a_firmware_entry_vector_enter: assert property ( // R9
      firmware_entry_vector && !exc_event && !irq_event && !reset_req_q
      |=> mode_q == sac_pkg::SAC_FW && prev_q == $past(mode_q))
      else $error("vector call did not enter firmware mode");
   a_exc_enter: assert property ( // R10
      exc_event && !in_exc_q && !reset_req_q |=> in_exc_q && mode_q == sac_pkg::SAC_APP)
      else $error("exception not entered");
   a_nested_reset: assert property ( // R11
      exc_event && in_exc_q |=> reset_req_q [*3])
      else $error("nested exception did not force reset");
   a_return_from_handler_instr_restore: assert property ( // R14
      return_from_handler_instr && !exc_event && !irq_event && !firmware_entry_vector
      && !reset_req_q |=> mode_q == $past(prev_q) && !in_exc_q)
      else $error("return did not restore mode");
   // A refused write must leave the key, system, bank, grant and interrupt option registers untouched.
   a_refused_write_keeps: assert property ( // R19
      acc && pwrite && !(hit && ok)
      |=> $stable(key_q) && $stable(mmu_q) && $stable(clk_q) && $stable(tamp_q)
      && $stable(bank_app_q) && $stable(bank_sup_q) && $stable(grant_q) && $stable(irq_fw_q))
      else $error("refused write changed a register");
   a_rng_write_refused: assert property ( // R4
      acc && pwrite && paddr == `SAC_OFS_RNG |=> pslverr_q)
      else $error("random output write accepted");
   a_sys_fw_closed: assert property ( // R8
      acc && mode_q == sac_pkg::SAC_FW
      && (paddr == `SAC_OFS_MMU || paddr == `SAC_OFS_CLK || paddr == `SAC_OFS_TAMP) |=> pslverr_q)
      else $error("system register reached from firmware mode");
   a_app_group_open: assert property ( // R15
      acc && is_app && paddr >= `SAC_OFS_PERI && paddr <= `SAC_OFS_PERI_END && paddr[1:0] == 2'h0
      |=> !pslverr_q)
      else $error("group register refused in application mode");
   a_bank_split: assert property ( // R6
      acc && pwrite && paddr == `SAC_OFS_BANK && is_app |=> $stable(bank_sup_q))
      else $error("application write reached supervisor copy");
   a_reset_sticks: assert property ( // R11
      reset_req_q |=> reset_req_q && $stable(mode_q) && $stable(in_exc_q))
      else $error("events acted after reset request");
   a_irq_mode: assert property ( // R12
      irq_event && !exc_event && !reset_req_q
      |=> mode_q == ($past(irq_fw_q) ? sac_pkg::SAC_FW : sac_pkg::SAC_APP))
      else $error("interrupt entered the wrong mode");
   a_boot_once: assert property ( // R17
      mode_q != sac_pkg::SAC_BOOT |=> mode_q != sac_pkg::SAC_BOOT)
      else $error("boot mode entered again");
   a_exc_one_cycle: assert property ( // R5
      sfr_exc_q |=> !sfr_exc_q)
      else $error("access exception longer than one cycle");

   c_fw_blocked: cover property (acc && mode_q == sac_pkg::SAC_FW ##1 pslverr_q);
   c_nested: cover property (exc_event && in_exc_q);
   c_irq_fw: cover property (irq_event && irq_fw_q ##1 mode_q == sac_pkg::SAC_FW);
   c_return_from_handler_instr_fw: cover property (return_from_handler_instr && prev_q == sac_pkg::SAC_FW);
   c_test_mode: cover property (boot_done && test_en && mode_q == sac_pkg::SAC_BOOT ##1 mode_q == sac_pkg::SAC_TEST);

endmodule

// file: inc/sac_defs.svh
// Offsets, reset values and group indices of the register access guard.
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_OFS_GRANT 8'h00
`define SAC_OFS_IRQCFG 8'h04
`define SAC_OFS_STAT 8'h08
`define SAC_OFS_BANK 8'h0C
`define SAC_OFS_KEY 8'h10
`define SAC_OFS_RNG 8'h14
`define SAC_OFS_MMU 8'h18
`define SAC_OFS_CLK 8'h1C
`define SAC_OFS_TAMP 8'h20
`define SAC_OFS_PERI 8'h40
`define SAC_OFS_PERI_END 8'h74
`define SAC_NGRP 14
`define SAC_GRP_RNG 4'h0
`define SAC_GRP_KEY 4'h1
`define SAC_RST_GRANT 14'h0000
`define SAC_RST_WORD 32'h00000000
`define SAC_RST_SEED 32'h5A5AC3E1
`define SAC_LFSR_TAPS 32'h80200003
`endif

// file: inc/sac_pkg.sv
// Types shared by the register access guard.
package sac_pkg;
   typedef enum logic [1:0] {
      SAC_BOOT,
      SAC_TEST,
      SAC_FW,
      SAC_APP
   } sac_mode_type;
   typedef logic [13:0] sac_grant_type;
endpackage

// file: verif/sac_cpu_model.sv
// CPU core model: APB master and control-flow event pulses.
`timescale 1ns/100ps
module sac_cpu_model (
   // Clock
   input wire logic mclk,
   // APB
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sfr_exc,
   // Events
   output logic boot_done,
   output logic test_en,
   output logic firmware_entry_vector,
   output logic exc_event,
   output logic irq_event,
   output logic return_from_handler_instr
);
   logic [4:0] ev_q = 5'h00;
   logic test_q = 1'b0;
   assign test_en = test_q;
   assign boot_done = ev_q[0];
   assign firmware_entry_vector = ev_q[1];
   assign exc_event = ev_q[2];
   assign irq_event = ev_q[3];
   assign return_from_handler_instr = ev_q[4];
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // Called right after a rising edge; the strap only matters while boot mode is left.
   task automatic set_test(input logic v);
      test_q <= v;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ex, output logic to);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      ex = sfr_exc;
      to = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines change so a stale address or word cannot pass for a held one.
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task automatic pulse(input int k);
      @(posedge mclk);
      ev_q[k] <= 1'b1;
      @(posedge mclk);
      ev_q <= 5'h00;
   endtask
endmodule

// file: verif/tb.sv
// Self-checking testbench for the register access guard.
`timescale 1ns/100ps
`include "sac_defs.svh"
module tb;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, sfr_exc, in_exc, reset_req;
   logic boot_done, test_en, firmware_entry_vector, exc_event, irq_event, return_from_handler_instr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, key_word, mmu_cfg, clk_cfg, tamper_cfg, rd_v;
   sac_pkg::sac_mode_type cpu_mode;
   int err_total = 0;
   int total_checks = 0;
   sac_guard dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .boot_done, .test_en, .firmware_entry_vector, .exc_event, .irq_event, .return_from_handler_instr,
      .cpu_mode, .in_exc, .sfr_exc, .reset_req, .key_word, .mmu_cfg, .clk_cfg, .tamper_cfg);
   sac_cpu_model cpu (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sfr_exc, .boot_done, .test_en, .firmware_entry_vector, .exc_event, .irq_event,
      .return_from_handler_instr);
   always #50 mclk = ~mclk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One access; a refusal must show on pslverr and sfr_exc in the same cycle.
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic e);
      logic err;
      logic ex;
      logic to;
      cpu.apb(wr, a, d, rd_v, err, ex, to);
      if (to) begin
         err_total++;
         give_verdict();
      end
      check("pslverr", 32'(err), 32'(e));
      check("sfr_exc", 32'(ex), 32'(e));
   endtask
   task automatic evt(input int k, input sac_pkg::sac_mode_type m, input logic x);
      cpu.pulse(k);
      #1;
      check("cpu_mode", 32'(cpu_mode), 32'(m));
      check("in_exc", 32'(in_exc), 32'(x));
   endtask
   task automatic t_boot();
      check("reset_req", 32'(reset_req), 32'h00000000);
      acc(1'b1, `SAC_OFS_BANK, 32'hB0B00001, 1'b0);
      evt(0, sac_pkg::SAC_FW, 1'b0);
      $display("done boot");
   endtask
   task automatic t_fw_locked();
      acc(1'b1, `SAC_OFS_PERI, 32'h11111111, 1'b1);
      acc(1'b1, `SAC_OFS_KEY, 32'hCAFE0001, 1'b1);
      check("key_word", key_word, 32'h00000000);
      acc(0, `SAC_OFS_KEY, 32'h00000000, 1'b1);
      check("prdata", rd_v, 32'h00000000);
      acc(0, `SAC_OFS_RNG, 32'h00000000, 1'b1);
      acc(1'b1, `SAC_OFS_MMU, 32'h0000ABCD, 1'b1);
      check("mmu_cfg", mmu_cfg, 32'h00000000);
      acc(1'b1, `SAC_OFS_GRANT, 32'h00000003, 1'b1);
      acc(1'b1, `SAC_OFS_IRQCFG, 32'h00000001, 1'b1);
      acc(0, 8'h30, 32'h00000000, 1'b1);
      $display("done fw locked");
   endtask
   task automatic t_app();
      evt(2, sac_pkg::SAC_APP, 1'b1);
      acc(1'b1, `SAC_OFS_GRANT, 32'h00000003, 1'b0);
      acc(0, `SAC_OFS_GRANT, 32'h00000000, 1'b0);
      check("grant", rd_v, 32'h00000003);
      acc(1'b1, `SAC_OFS_KEY, 32'hCAFE0002, 1'b0);
      check("key_word", key_word, 32'hCAFE0002);
      acc(0, `SAC_OFS_KEY, 32'h00000000, 1'b1);
      acc(0, `SAC_OFS_RNG, 32'h00000000, 1'b0);
      acc(1'b1, `SAC_OFS_RNG, 32'h00000001, 1'b1);
      acc(1'b1, `SAC_OFS_TAMP, 32'h0000BEEF, 1'b0);
      check("tamper_cfg", tamper_cfg, 32'h0000BEEF);
      acc(1'b1, `SAC_OFS_IRQCFG, 32'h00000001, 1'b0);
      acc(1'b1, `SAC_OFS_BANK, 32'hA0A00002, 1'b0);
      acc(1'b1, `SAC_OFS_PERI + 8'h08, 32'h44444444, 1'b0);
      $display("done app");
   endtask
   task automatic t_fw_granted();
      evt(1, sac_pkg::SAC_FW, 1'b1);
      acc(1'b1, `SAC_OFS_PERI, 32'h22222222, 1'b0);
      acc(1'b1, `SAC_OFS_PERI + 8'h08, 32'h33333333, 1'b1);
      acc(0, `SAC_OFS_BANK, 32'h00000000, 1'b0);
      check("bank fw", rd_v, 32'hB0B00001);
      acc(1'b1, `SAC_OFS_KEY, 32'hCAFE0003, 1'b0);
      check("key_word", key_word, 32'hCAFE0003);
      evt(4, sac_pkg::SAC_APP, 1'b0);
      acc(0, `SAC_OFS_BANK, 32'h00000000, 1'b0);
      check("bank app", rd_v, 32'hA0A00002);
      acc(0, `SAC_OFS_PERI + 8'h08, 32'h00000000, 1'b0);
      check("peri 2", rd_v, 32'h44444444);
      $display("done fw granted");
   endtask
   task automatic t_irq_nest();
      evt(3, sac_pkg::SAC_FW, 1'b0);
      evt(4, sac_pkg::SAC_APP, 1'b0);
      evt(2, sac_pkg::SAC_APP, 1'b1);
      cpu.pulse(2);
      #1;
      check("reset_req", 32'(reset_req), 32'h00000001);
      // Once a reset is pending no event may move the mode any more.
      evt(1, sac_pkg::SAC_APP, 1'b1);
      $display("done irq nest");
   endtask
   // Mid-run reset with the test strap set, so boot mode leaves to test mode.
   task automatic t_test_mode();
      @(posedge mclk);
      rstn <= 1'b0;
      cpu.set_test(1'b1);
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      #1;
      check("cpu_mode", 32'(cpu_mode), 32'(sac_pkg::SAC_BOOT));
      check("reset_req", 32'(reset_req), 32'h00000000);
      check("in_exc", 32'(in_exc), 32'h00000000);
      check("key_word", key_word, 32'h00000000);
      check("tamper_cfg", tamper_cfg, 32'h00000000);
      evt(0, sac_pkg::SAC_TEST, 1'b0);
      acc(1'b1, `SAC_OFS_CLK, 32'h00C10C00, 1'b0);
      check("clk_cfg", clk_cfg, 32'h00C10C00);
      acc(1'b1, `SAC_OFS_BANK, 32'hC0C00003, 1'b0);
      acc(0, `SAC_OFS_BANK, 32'h00000000, 1'b0);
      check("bank test", rd_v, 32'hC0C00003);
      acc(0, `SAC_OFS_STAT, 32'h00000000, 1'b0);
      check("stat", rd_v, 32'h00000001);
      acc(1'b1, `SAC_OFS_STAT, 32'h0000003F, 1'b1);
      evt(1, sac_pkg::SAC_FW, 1'b0);
      evt(0, sac_pkg::SAC_FW, 1'b0);
      acc(0, `SAC_OFS_STAT, 32'h00000000, 1'b0);
      check("stat fw", rd_v, 32'h00000012);
      $display("done test mode");
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      #1;
      check("cpu_mode", 32'(cpu_mode), 32'(sac_pkg::SAC_BOOT));
      t_boot();
      t_fw_locked();
      t_app();
      t_fw_granted();
      t_irq_nest();
      t_test_mode();
      give_verdict();
   end
endmodule
